// ==== hdl/tpc_consts.vh ====
/*
 tourniquet panel controller constants: bus offsets, reset values,
 limits and times in milliseconds.
 assumes a 100 MHz pclk and a millisecond enable derived from it.
*/
`ifndef TPC_CONSTS_VH
`define TPC_CONSTS_VH

`define TPC_CLK_HZ 100000000
`define TPC_CLK_PER_MS (`TPC_CLK_HZ / 1000)

`define TPC_OFS_CTRL 8'h00
`define TPC_OFS_STAT 8'h04
`define TPC_OFS_SETP 8'h08
`define TPC_OFS_ELAP 8'h0C

`define TPC_CTRL_RST 8'hC8
`define TPC_ST_MAIN 0
`define TPC_ST_SEC 1
`define TPC_ST_ABN 2
`define TPC_ST_PAM 3
`define TPC_ST_PAS 4
`define TPC_ST_TOV 5
`define TPC_ST_TONE 6
`define TPC_ST_SIL 7
`define TPC_SETP_TIME_LSB 16

`define TPC_P_MAX 9'h1DB
`define TPC_P_DEF 9'h0C8
`define TPC_P_ABN 9'h032
`define TPC_P_TOL 9'h00F
`define TPC_T_MAX 8'hF0
`define TPC_T_DEF 8'h3C
`define TPC_FINE_STEPS 4'hA
`define TPC_COARSE 3'h5

`define TPC_BLANK_MS 11'h064
`define TPC_VIEW_MS 11'h5DC
`define TPC_PA_DELAY_MS 11'h5DC
`define TPC_DEF_SGL_MS 10'h064
`define TPC_DEF_DUAL_MS 10'h258
`define TPC_SIL_MS 15'h7530
`define TPC_MIN_MS 16'hEA60
`define TPC_FLASH_MS 8'hFA

`endif

// ==== hdl/tpc_panel.v ====
/*
 front-panel logic of a two-cuff tourniquet controller: setpoint
 adjusters, cuff inflate/deflate control, displays, lamps, tone,
 abnormal start-up, APB status/control registers.
 assumes panel switches and sensed pressures synchronous to pclk,
 debounced, and pressures valid at reset release.
*/
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "tpc_consts.vh"

module tpc_adjust #(
  parameter W = 9,
  parameter [W-1:0] MAXV = 0,
  parameter [W-1:0] DEFV = 0
) (
  input wire pclk, // clock
  input wire presetn, // async reset
  input wire tick_ms, // 1 ms enable
  input wire sw_up, // increase switch
  input wire sw_dn, // decrease switch
  input wire [7:0] step_ms, // repeat interval
  input wire load, // force value
  input wire [W-1:0] load_val, // forced value
  output reg [W-1:0] val_reg, // stored setting
  output reg show_reg, // display shows setting
  output reg blank_reg // display blanked
);
  localparam S_IDLE = 5'b00001;
  localparam S_BLK1 = 5'b00010;
  localparam S_VIEW = 5'b00100;
  localparam S_BLK2 = 5'b01000;
  localparam S_STEP = 5'b10000;
  reg [4:0] st_reg;
  reg [4:0] st_next;
  reg [10:0] ms_reg;
  reg [3:0] chg_reg;
  wire held = sw_up | sw_dn;
  wire [W-1:0] inc;
  wire step_now;
  assign inc = (chg_reg < `TPC_FINE_STEPS) ? {{(W-3){1'b0}}, 3'h1} :
    {{(W-3){1'b0}}, `TPC_COARSE};
  // the counter restarts at zero on each step, so the step falls on the tick that ends the interval
  assign step_now = (st_reg == S_STEP) && tick_ms &&
    (ms_reg + 11'h001 >= {3'h0, step_ms});

  always @* begin
    st_next = st_reg;
    case (st_reg)
      S_IDLE: if (held) st_next = S_BLK1;
      S_BLK1: if (!held) st_next = S_IDLE;
        else if (ms_reg == `TPC_BLANK_MS) st_next = S_VIEW;
      S_VIEW: if (!held) st_next = S_IDLE;
        else if (ms_reg == `TPC_VIEW_MS) st_next = S_BLK2;
      S_BLK2: if (!held) st_next = S_IDLE;
        else if (ms_reg == `TPC_BLANK_MS) st_next = S_STEP;
      S_STEP: if (!held) st_next = S_IDLE;
      default: st_next = S_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= S_IDLE;
      ms_reg <= 11'h000;
      chg_reg <= 4'h0;
      val_reg <= DEFV;
      show_reg <= 1'b0;
      blank_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      show_reg <= (st_next == S_VIEW) || (st_next == S_STEP);
      blank_reg <= (st_next == S_BLK1) || (st_next == S_BLK2);
      if (st_next != st_reg || step_now)
        ms_reg <= 11'h000;
      else if (tick_ms && ms_reg != 11'h7FF)
        ms_reg <= ms_reg + 11'h001;
      if (st_next == S_IDLE)
        chg_reg <= 4'h0;
      else if (step_now && chg_reg != `TPC_FINE_STEPS)
        chg_reg <= chg_reg + 4'h1;
      if (load)
        val_reg <= load_val;
      else if (step_now && sw_up) begin
        if (MAXV - val_reg < inc)
          val_reg <= MAXV;
        else
          val_reg <= val_reg + inc;
      end else if (step_now) begin
        if (val_reg < inc)
          val_reg <= {W{1'b0}};
        else
          val_reg <= val_reg - inc;
      end
    end
  end
endmodule // tpc_adjust

module tpc_panel #(
  parameter CLK_PER_MS = `TPC_CLK_PER_MS
) (
  input wire pclk, // 100 MHz clock
  input wire presetn, // async reset, low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb write
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error
  input wire sw_p_up, // pressure +
  input wire sw_p_dn, // pressure -
  input wire sw_t_up, // time +
  input wire sw_t_dn, // time -
  input wire sw_main_inf, // main inflate
  input wire sw_main_def, // main deflate
  input wire sw_sec_inf, // second inflate
  input wire sw_sec_def, // second deflate
  input wire sw_silence, // alarm silence
  input wire mode_dual, // 1 = dual cuff
  input wire [8:0] press_main, // sensed main mmHg
  input wire [8:0] press_sec, // sensed second mmHg
  input wire inflating_main, // regulator filling main
  input wire inflating_sec, // regulator filling second
  input wire fault, // internal malfunction
  input wire ext_alarm, // other alarm present
  output reg [8:0] press_disp, // pressure display value
  output reg press_blank, // pressure display dark
  output reg [7:0] time_disp, // time display value
  output reg time_blank, // time display dark
  output reg lamp_main, // main cuff light
  output reg lamp_sec, // second cuff light
  output reg lamp_silence, // silence switch light
  output reg tone, // alarm tone on
  output reg reg_main, // regulate main cuff
  output reg reg_sec, // regulate second cuff
  output reg [8:0] setpt_out // pressure setpoint
);
  reg [16:0] div_reg;
  reg tick_ms;
  reg st_done_reg;
  reg abn_reg;
  reg sil_q;
  reg [14:0] sil_ms_reg;
  reg [10:0] pa_ms_reg;
  reg [15:0] min_ms_reg;
  reg [7:0] elap_reg;
  reg [7:0] ph_ms_reg;
  reg phase_reg;
  reg [7:0] ctrl_reg;
  wire [8:0] setp;
  wire [7:0] tset;
  wire show_p;
  wire blank_p;
  wire show_t;
  wire blank_t;
  wire [1:0] cuff_on;
  wire [1:0] dev;
  wire [1:0] inf_ev;
  wire [1:0] inf_sw = {sw_sec_inf, sw_main_inf};
  wire [1:0] def_sw = {sw_sec_def, sw_main_def};
  wire [1:0] inflating = {inflating_sec, inflating_main};
  wire [17:0] press_all = {press_sec, press_main};
  wire [1:0] ge50 = {press_sec >= `TPC_P_ABN, press_main >= `TPC_P_ABN};
  wire abn_start = ~st_done_reg & (|ge50);
  wire [8:0] abn_setp = (press_sec > press_main) ? press_sec : press_main;
  wire sil_edge = sw_silence & ~sil_q;
  wire silenced = sil_ms_reg != 15'h0000;
  wire any_on = |cuff_on;
  wire time_over = elap_reg > tset;
  wire pa_tone = pa_ms_reg == `TPC_PA_DELAY_MS;
  wire alarm_any = abn_reg | (|dev) | time_over | fault | ext_alarm;
  wire use_sec = mode_dual & cuff_on[1] & ~cuff_on[0];
  wire [8:0] sensed = use_sec ? press_sec : press_main;
  wire [8:0] sensed_clip = (sensed > `TPC_P_MAX) ? `TPC_P_MAX : sensed;
  wire p_flash = ~show_p & (use_sec ? dev[1] : dev[0]);
  wire t_flash = ~show_t & time_over;
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite;
  reg [31:0] rd_mux;
  reg rd_err;

  tpc_adjust #(.W(9), .MAXV(`TPC_P_MAX), .DEFV(`TPC_P_DEF)) u_padj (
    .pclk(pclk), .presetn(presetn), .tick_ms(tick_ms), .sw_up(sw_p_up), .sw_dn(sw_p_dn),
    .step_ms(ctrl_reg), .load(abn_start), .load_val(abn_setp),
    .val_reg(setp), .show_reg(show_p), .blank_reg(blank_p));

  tpc_adjust #(.W(8), .MAXV(`TPC_T_MAX), .DEFV(`TPC_T_DEF)) u_tadj (
    .pclk(pclk), .presetn(presetn), .tick_ms(tick_ms), .sw_up(sw_t_up), .sw_dn(sw_t_dn),
    .step_ms(ctrl_reg), .load(1'b0), .load_val(8'h00),
    .val_reg(tset), .show_reg(show_t), .blank_reg(blank_t));

  // every slower rate in the block runs off this millisecond enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 17'h0_0000;
      tick_ms <= 1'b0;
    end else begin
      tick_ms <= div_reg == CLK_PER_MS[16:0] - 17'h0_0001;
      if (div_reg == CLK_PER_MS[16:0] - 17'h0_0001)
        div_reg <= 17'h0_0000;
      else
        div_reg <= div_reg + 17'h0_0001;
    end
  end

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_cuff
      reg on_reg;
      reg inf_q;
      reg [9:0] hold_reg;
      wire en = (c == 0) | mode_dual;
      wire refuse = mode_dual & inflating[1-c];
      wire [9:0] need = mode_dual ? `TPC_DEF_DUAL_MS : `TPC_DEF_SGL_MS;
      wire def_ok = def_sw[c] & en & ~refuse;
      wire [8:0] p = press_all[c*9 +: 9];
      wire [8:0] diff = (p > setp) ? p - setp : setp - p;
      assign inf_ev[c] = inf_sw[c] & ~inf_q & en;
      assign cuff_on[c] = on_reg;
      assign dev[c] = on_reg & (diff > `TPC_P_TOL);
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          on_reg <= 1'b0;
          inf_q <= 1'b0;
          hold_reg <= 10'h000;
        end else begin
          inf_q <= inf_sw[c];
          if (!def_ok)
            hold_reg <= 10'h000;
          else if (tick_ms && hold_reg != need)
            hold_reg <= hold_reg + 10'h001;
          if (!st_done_reg)
            on_reg <= ge50[c];
          else if (def_ok && hold_reg == need)
            on_reg <= 1'b0;
          else if (inf_ev[c])
            on_reg <= 1'b1;
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_done_reg <= 1'b0;
      abn_reg <= 1'b0;
      sil_q <= 1'b0;
      sil_ms_reg <= 15'h0000;
      pa_ms_reg <= 11'h000;
    end else begin
      st_done_reg <= 1'b1;
      sil_q <= sw_silence;
      if (abn_start)
        abn_reg <= 1'b1;
      else if (sil_edge)
        abn_reg <= 1'b0;
      if (sil_edge)
        sil_ms_reg <= `TPC_SIL_MS;
      else if (tick_ms && silenced)
        sil_ms_reg <= sil_ms_reg - 15'h0001;
      // movement can briefly push pressure out; hold the tone back
      if (!(|dev))
        pa_ms_reg <= 11'h000;
      else if (tick_ms && !pa_tone)
        pa_ms_reg <= pa_ms_reg + 11'h001;
    end
  end

  // elapsed time restarts only when a cuff is inflated from all-deflated
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_ms_reg <= 16'h0000;
      elap_reg <= 8'h00;
    end else if ((|inf_ev) && !any_on) begin
      min_ms_reg <= 16'h0000;
      elap_reg <= 8'h00;
    end else if (tick_ms && any_on) begin
      if (min_ms_reg == `TPC_MIN_MS - 16'h0001) begin
        min_ms_reg <= 16'h0000;
        if (elap_reg != `TPC_T_MAX)
          elap_reg <= elap_reg + 8'h01;
      end else begin
        min_ms_reg <= min_ms_reg + 16'h0001;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_ms_reg <= 8'h00;
      phase_reg <= 1'b0;
    end else if (tick_ms) begin
      if (ph_ms_reg == `TPC_FLASH_MS - 8'h01) begin
        ph_ms_reg <= 8'h00;
        phase_reg <= ~phase_reg;
      end else begin
        ph_ms_reg <= ph_ms_reg + 8'h01;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      press_disp <= 9'h000;
      press_blank <= 1'b0;
      time_disp <= 8'h00;
      time_blank <= 1'b0;
      lamp_main <= 1'b0;
      lamp_sec <= 1'b0;
      lamp_silence <= 1'b0;
      tone <= 1'b0;
      reg_main <= 1'b0;
      reg_sec <= 1'b0;
      setpt_out <= `TPC_P_DEF;
    end else begin
      press_disp <= show_p ? setp : sensed_clip;
      press_blank <= blank_p | (p_flash & phase_reg);
      time_disp <= show_t ? tset : elap_reg;
      time_blank <= blank_t | (t_flash & phase_reg);
      lamp_main <= cuff_on[0] & ~(dev[0] & phase_reg);
      lamp_sec <= cuff_on[1] & ~(dev[1] & phase_reg);
      lamp_silence <= alarm_any;
      // a malfunction tone ignores the silence timer
      tone <= fault | (~silenced & (abn_reg | pa_tone | time_over | ext_alarm));
      reg_main <= cuff_on[0];
      reg_sec <= cuff_on[1];
      setpt_out <= setp;
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `TPC_OFS_CTRL: rd_mux[7:0] = ctrl_reg;
      `TPC_OFS_STAT: begin
        rd_mux[`TPC_ST_MAIN] = cuff_on[0];
        rd_mux[`TPC_ST_SEC] = cuff_on[1];
        rd_mux[`TPC_ST_ABN] = abn_reg;
        rd_mux[`TPC_ST_PAM] = dev[0];
        rd_mux[`TPC_ST_PAS] = dev[1];
        rd_mux[`TPC_ST_TOV] = time_over;
        rd_mux[`TPC_ST_TONE] = tone;
        rd_mux[`TPC_ST_SIL] = silenced;
      end
      `TPC_OFS_SETP: begin
        rd_mux[8:0] = setp;
        rd_mux[`TPC_SETP_TIME_LSB +: 8] = tset;
      end
      `TPC_OFS_ELAP: rd_mux[7:0] = elap_reg;
      default: rd_err = 1'b1;
    endcase
  end

  // answers are prepared in the setup cycle, so every access has no wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_reg <= `TPC_CTRL_RST;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & rd_err;
      prdata <= (apb_setup & ~pwrite & ~rd_err) ? rd_mux : 32'h0000_0000;
      if (apb_wr && paddr == `TPC_OFS_CTRL)
        ctrl_reg <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
    end
  end
endmodule // tpc_panel

// ==== verif/test_tpc_panel.sv ====
/* self-checking bench for tpc_panel: apb master, operator model, lfsr pressures.
 assumes CLK_PER_MS of 10, so one ms lasts ten pclk cycles. */
`timescale 1ns/1ps
`include "tpc_consts.vh"
module test_tpc_panel;
  localparam int MS = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic mode_dual = 1'b0;
  logic [8:0] press_main = 9'h000;
  logic [8:0] press_sec = 9'h000;
  logic inflating_sec = 1'b0;
  logic inflating_main = 1'b0;
  logic [1:0] fl;
  logic fault = 1'b0;
  logic ext_alarm = 1'b0;
  logic go = 1'b0;
  logic [3:0] code = 4'h0;
  logic [19:0] len = 20'h0_0000;
  logic [31:0] q;
  logic e;
  logic [7:0] lfsr;
  wire [8:0] sw;
  wire busy, pready, pslverr, press_blank, time_blank, lamp_main, lamp_sec, lamp_silence;
  wire tone, reg_main, reg_sec;
  wire [31:0] prdata;
  wire [8:0] press_disp, setpt_out;
  wire [7:0] time_disp;
  int err_total = 0;
  int n_compared = 0;
  always #5 pclk = ~pclk;
  tpc_op_model tpc_op_model_inst (.pclk(pclk), .go(go), .code(code), .len(len), .sw(sw),
    .busy(busy));
  tpc_panel #(.CLK_PER_MS(MS)) tpc_panel_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sw_p_up(sw[0]), .sw_p_dn(sw[1]), .sw_t_up(sw[2]),
    .sw_t_dn(sw[3]), .sw_main_inf(sw[4]), .sw_main_def(sw[5]), .sw_sec_inf(sw[6]),
    .sw_sec_def(sw[7]), .sw_silence(sw[8]), .mode_dual(mode_dual), .press_main(press_main),
    .press_sec(press_sec), .inflating_main(inflating_main), .inflating_sec(inflating_sec),
    .fault(fault), .ext_alarm(ext_alarm), .press_disp(press_disp), .press_blank(press_blank),
    .time_disp(time_disp), .time_blank(time_blank), .lamp_main(lamp_main),
    .lamp_sec(lamp_sec), .lamp_silence(lamp_silence), .tone(tone), .reg_main(reg_main),
    .reg_sec(reg_sec), .setpt_out(setpt_out));
  function automatic logic [7:0] nxt_rand(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [8:0] nxt_val(logic [8:0] v, int k, logic up, int mx);
    int r;
    r = up ? int'(v) + ((k < 10) ? 1 : 5) : int'(v) - ((k < 10) ? 1 : 5);
    if (r > mx) r = mx;
    if (r < 0) r = 0;
    return 9'(r);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic kick(input int c, input int ms);
    code <= 4'(c);
    len <= 20'(ms * MS);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic press(input int c, input int ms);
    kick(c, ms);
    while (busy !== 1'b0) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask
  // tracks each new non-blank value shown while a setpoint switch is held
  task automatic steps(input int c, input int ms, input int mx, input int st, input logic tm);
    logic [8:0] v;
    logic [8:0] pv;
    logic blk;
    int k;
    blk = 1'b0;
    k = -1;
    pv = 9'h000;
    kick(c, ms);
    while (busy === 1'b1) begin
      @(posedge pclk);
      v = tm ? {1'b0, time_disp} : press_disp;
      if ((tm ? time_blank : press_blank) === 1'b1) blk = 1'b1;
      else if (blk && (k < 0 || v !== pv)) begin
        if (k < 0) check(v, st);
        else check(v, nxt_val(pv, k, c % 2 == 0, mx));
        pv = v;
        k++;
      end
    end
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    stop_test();
  end
  initial begin
    lfsr = 8'h42;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(0, `TPC_OFS_SETP, 0); check(q, {8'h00, `TPC_T_DEF, 7'h00, `TPC_P_DEF});
    apb(0, `TPC_OFS_CTRL, 0); check(q, 32'h0000_00C8);
    apb(1, `TPC_OFS_CTRL, 0);
    apb(1, `TPC_OFS_STAT, 32'hFFFF_FFFF);
    apb(0, 8'h10, 0); check({q[30:0], e}, 32'h0000_0001);
    apb(0, `TPC_OFS_CTRL, 0); check(q, 32'h0000_0001);
    apb(0, `TPC_OFS_STAT, 0); check(q, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt_rand(lfsr);
      press_main <= {lfsr, lfsr[7]};
      press_sec <= {lfsr[3:0], lfsr[7:3]};
      repeat (4) @(posedge pclk);
      check(press_disp, (press_main > 475) ? 9'h1DB : press_main);
    end
    press_main <= 9'h000;
    steps(0, 1790, 475, 200, 0);
    apb(0, `TPC_OFS_SETP, 0); check(q[8:0], `TPC_P_MAX);
    steps(3, 1740, 240, 60, 1);
    apb(0, `TPC_OFS_SETP, 0); check(q[23:16], 8'h00);
    press_main <= `TPC_P_MAX;
    press_sec <= 9'h1D0;
    press(4, 5); check({reg_main, lamp_main}, 2'b11);
    press(5, 110); check({reg_main, lamp_main}, 2'b00);
    mode_dual <= 1'b1;
    press(4, 5);
    press(6, 5); check({reg_main, reg_sec, lamp_main, lamp_sec}, 4'hF);
    inflating_sec <= 1'b1;
    press(5, 700); check(reg_main, 1'b1);
    inflating_sec <= 1'b0;
    press(5, 300); check(reg_main, 1'b1);
    press(5, 650); check(reg_main, 1'b0);
    check(press_disp, 9'h1D0);
    mode_dual <= 1'b0;
    press(7, 650); check(reg_sec, 1'b1);
    mode_dual <= 1'b1;
    inflating_main <= 1'b1;
    press(7, 650); check(reg_sec, 1'b1);
    inflating_main <= 1'b0;
    press(7, 650); check(reg_sec, 1'b0);
    mode_dual <= 1'b0;
    press(6, 5); check(reg_sec, 1'b0);
    ext_alarm <= 1'b1;
    repeat (5) @(posedge pclk);
    check(lamp_silence, 1'b1);
    ext_alarm <= 1'b0;
    fault <= 1'b1;
    press(8, 5); check(tone, 1'b1);
    fault <= 1'b0;
    presetn <= 1'b0;
    mode_dual <= 1'b1;
    press_main <= 9'h078;
    press_sec <= 9'h073;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, `TPC_OFS_STAT, 0); check(q & 32'h0000_007F, 32'h0000_0047);
    apb(0, `TPC_OFS_SETP, 0); check(q[8:0], 9'h078);
    check(setpt_out, 9'h078);
    press(8, 5);
    apb(0, `TPC_OFS_STAT, 0); check(q & 32'h0000_007F, 32'h0000_0003);
    check(lamp_silence, 1'b0);
    // main cuff 40 above setpoint: display and main light must both blink
    press_main <= 9'h0A0;
    fl = 2'b00;
    repeat (3000) begin
      @(posedge pclk);
      fl = fl | {press_blank, ~lamp_main};
    end
    check(fl, 2'b11);
    apb(0, `TPC_OFS_STAT, 0); check(q[3], 1'b1);
    stop_test();
  end
endmodule // test_tpc_panel

// ==== verif/tpc_op_model.sv ====
/* operator model: holds one panel switch for a set number of cycles.
 assumes go is raised only while busy is low. */
`timescale 1ns/1ps
module tpc_op_model (
  input wire pclk, // clock
  input wire go, // start a press
  input wire [3:0] code, // switch index
  input wire [19:0] len, // press cycles
  output reg [8:0] sw, // switch levels
  output reg busy // pressing
);
  reg [19:0] cnt_reg = 20'h0_0000;
  initial begin
    sw = 9'h000;
    busy = 1'b0;
  end
  always @(posedge pclk) begin
    if (go && !busy) begin
      sw <= 9'h001 << code;
      cnt_reg <= len;
      busy <= 1'b1;
    end else if (busy && cnt_reg == 20'h0_0001) begin
      sw <= 9'h000;
      busy <= 1'b0;
    end else if (busy) begin
      cnt_reg <= cnt_reg - 20'h0_0001;
    end
  end
endmodule // tpc_op_model

// ==== verif/tpc_panel_props.sv ====
/* assertions on the ports of tpc_panel.
 assumes CLK_PER_MS matches the bound instance. */
`timescale 1ns/1ps
`include "tpc_consts.vh"
module tpc_panel_props #(
  parameter CLK_PER_MS = 100000
) (
  input wire pclk, // clock
  input wire presetn, // reset, low
  input wire sw_p_up, // pressure +
  input wire sw_main_inf, // main inflate
  input wire sw_main_def, // main deflate
  input wire mode_dual, // dual mode
  input wire [8:0] press_main, // main sensed
  input wire inflating_sec, // second filling
  input wire fault, // malfunction
  input wire ext_alarm, // other alarm
  input wire [8:0] press_disp, // pressure shown
  input wire press_blank, // pressure dark
  input wire [7:0] time_disp, // time shown
  input wire lamp_main, // main light
  input wire lamp_sec, // second light
  input wire lamp_silence, // silence light
  input wire tone, // tone
  input wire reg_main, // main regulate
  input wire reg_sec, // second regulate
  input wire [8:0] setpt_out // setpoint
);
  // one ms of slack allows for the tick phase at press time
  localparam int SGL = 99 * CLK_PER_MS;
  localparam int DUAL = 599 * CLK_PER_MS;
  reg [31:0] def_cnt_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      def_cnt_reg <= 32'h0000_0000;
    end else begin
      def_cnt_reg <= sw_main_def ? def_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_abn_power;
    $rose(presetn) && press_main >= `TPC_P_ABN;
  endsequence
  sequence s_abn_shown;
    ##[0:3] (lamp_silence && reg_main);
  endsequence
  a_press_range: assert property (press_disp <= `TPC_P_MAX && setpt_out <= `TPC_P_MAX)
    else $error("pressure value above limit");
  a_time_range: assert property (time_disp <= `TPC_T_MAX)
    else $error("time value above limit");
  a_lamp_cuff: assert property (!(lamp_main && !reg_main) && !(lamp_sec && !reg_sec))
    else $error("cuff light on with cuff off");
  a_main_inflate: assert property ($rose(sw_main_inf) && !reg_main |-> ##[1:3] reg_main)
    else $error("main inflate not taken");
  a_deflate_hold: assert property ($fell(reg_main) |-> def_cnt_reg >= (mode_dual ? DUAL : SGL))
    else $error("main deflated too early");
  a_dual_refuse: assert property ((mode_dual && inflating_sec && reg_main) [*3] |=> reg_main)
    else $error("deflate while other cuff fills");
  a_silence_lamp: assert property (ext_alarm [*3] |-> lamp_silence)
    else $error("silence light off during alarm");
  a_fault_tone: assert property (fault [*3] |-> tone)
    else $error("malfunction tone missing");
  a_view_blank: assert property ($rose(sw_p_up) |-> ##[1:3] press_blank)
    else $error("pressure display not blanked");
  a_abn_start: assert property (s_abn_power |-> s_abn_shown)
    else $error("abnormal start not flagged");
endmodule // tpc_panel_props
bind tpc_panel tpc_panel_props #(.CLK_PER_MS(CLK_PER_MS)) tpc_panel_props_inst (
  .pclk(pclk), .presetn(presetn), .sw_p_up(sw_p_up), .sw_main_inf(sw_main_inf),
  .sw_main_def(sw_main_def), .mode_dual(mode_dual), .press_main(press_main),
  .inflating_sec(inflating_sec), .fault(fault), .ext_alarm(ext_alarm),
  .press_disp(press_disp), .press_blank(press_blank), .time_disp(time_disp),
  .lamp_main(lamp_main), .lamp_sec(lamp_sec), .lamp_silence(lamp_silence), .tone(tone),
  .reg_main(reg_main), .reg_sec(reg_sec), .setpt_out(setpt_out));
